// [hw/apc_pin_config.v]
`timescale 1ns/1ps
`include "apc_consts.vh"

module apc_pin_config (
  input  wire        clock,
  input  wire        rst,
  input  wire [13:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [13:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire [12:0] pin_in,
  input  wire [12:0] periph_out,
  input  wire [12:0] periph_oe,
  input  wire        other_bandgap_request,
  output reg  [12:0] pin_out,
  output reg  [12:0] pin_oe,
  output reg  [12:0] pin_digital_in,
  output reg  [12:0] pin_analog_enable,
  output reg         bandgap_enable,
  output reg         converter_bandgap_route
);

  reg  [7:0]  sel_low_reg;
  reg  [7:0]  sel_high_reg;
  reg  [7:0]  conv_ctrl_reg;
  reg  [13:0] aw_addr_reg;
  reg         aw_held_reg;
  reg  [31:0] w_data_reg;
  reg  [3:0]  w_strb_reg;
  reg         w_held_reg;
  reg  [12:0] pin_sync1_reg;
  reg  [12:0] pin_sync2_reg;
  reg         bg_sync1_reg;
  reg         bg_sync2_reg;
  reg  [31:0] rd_next;
  reg         rd_hit;
  wire [12:0] pin_digital_select;
  wire        bandgap_request;
  wire        wr_go;
  wire        wr_lane0;
  wire        wr_hit;

  assign pin_digital_select = {sel_high_reg[`APC_HIGH_PIN_DIGITAL_SELECT_MSB:0], sel_low_reg};
  assign bandgap_request    = sel_high_reg[`APC_HIGH_BGREQ_BIT];
  assign wr_go              = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign wr_lane0           = w_strb_reg[0];
  assign wr_hit             = (aw_addr_reg == `APC_ADDR_SEL_LOW) || (aw_addr_reg == `APC_ADDR_SEL_HIGH) ||
                              (aw_addr_reg == `APC_ADDR_CONV_CTRL);

  // Write channels are taken independently, in either order
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      aw_addr_reg   <= 14'h0000;
      aw_held_reg   <= 1'b0;
      w_data_reg    <= 32'h00000000;
      w_strb_reg    <= 4'h0;
      w_held_reg    <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `APC_RESP_OKAY;
      sel_low_reg   <= `APC_SEL_LOW_RESET;
      sel_high_reg  <= `APC_SEL_HIGH_RESET;
      conv_ctrl_reg <= `APC_CONV_CTRL_RESET;
    end
    else
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      if (s_axi_awvalid && !aw_held_reg && !s_axi_awready)
      begin
        s_axi_awready <= 1'b1;
        aw_addr_reg   <= s_axi_awaddr;
        aw_held_reg   <= 1'b1;
      end
      if (s_axi_wvalid && !w_held_reg && !s_axi_wready)
      begin
        s_axi_wready <= 1'b1;
        w_data_reg   <= s_axi_wdata;
        w_strb_reg   <= s_axi_wstrb;
        w_held_reg   <= 1'b1;
      end
      if (wr_go)
      begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `APC_RESP_OKAY : `APC_RESP_SLVERR;
        if (wr_lane0 && aw_addr_reg == `APC_ADDR_SEL_LOW)
          sel_low_reg <= w_data_reg[7:0];
        if (wr_lane0 && aw_addr_reg == `APC_ADDR_SEL_HIGH)
          sel_high_reg <= {w_data_reg[7:6], 1'b0, w_data_reg[4:0]};
        if (wr_lane0 && aw_addr_reg == `APC_ADDR_CONV_CTRL)
          conv_ctrl_reg <= w_data_reg[7:0];
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  always @*
  begin
    rd_next = 32'h00000000;
    rd_hit  = 1'b1;
    case (s_axi_araddr)
      `APC_ADDR_SEL_LOW:   rd_next[7:0] = sel_low_reg;
      `APC_ADDR_SEL_HIGH:  rd_next[7:0] = sel_high_reg;
      `APC_ADDR_CONV_CTRL: rd_next[7:0] = conv_ctrl_reg;
      default:             rd_hit = 1'b0;
    endcase
  end

  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `APC_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= 1'b0;
      if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready)
      begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_next;
        s_axi_rresp   <= rd_hit ? `APC_RESP_OKAY : `APC_RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // Pads and other requesters are asynchronous to this clock
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      pin_sync1_reg <= 13'h0000;
      pin_sync2_reg <= 13'h0000;
      bg_sync1_reg  <= 1'b0;
      bg_sync2_reg  <= 1'b0;
    end
    else
    begin
      pin_sync1_reg <= pin_in;
      pin_sync2_reg <= pin_sync1_reg;
      bg_sync1_reg  <= other_bandgap_request;
      bg_sync2_reg  <= bg_sync1_reg;
    end
  end

  // Outputs registered; select changes land one cycle after the write edge
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      pin_out                 <= 13'h0000;
      pin_oe                  <= 13'h0000;
      pin_digital_in          <= 13'h0000;
      pin_analog_enable       <= 13'h1FFF;
      bandgap_enable          <= 1'b0;
      converter_bandgap_route <= 1'b0;
    end
    else
    begin
      pin_out           <= periph_out & pin_digital_select;
      pin_oe            <= periph_oe & pin_digital_select;
      pin_digital_in    <= pin_sync2_reg & pin_digital_select;
      pin_analog_enable <= ~pin_digital_select;
      bandgap_enable    <= bandgap_request | bg_sync2_reg;
      converter_bandgap_route <=
        (conv_ctrl_reg[`APC_CHSEL_MSB:`APC_CHSEL_LSB] == `APC_CHSEL_BANDGAP);
    end
  end

endmodule // apc_pin_config

// [hw/apc_consts.vh]
`ifndef APC_CONSTS_VH
`define APC_CONSTS_VH

// Register indices; each byte address is its index times four
`define APC_IDX_SEL_LOW       12'hF48
`define APC_IDX_SEL_HIGH      12'hF49
`define APC_ADDR_SEL_LOW      14'h3D20
`define APC_ADDR_SEL_HIGH     14'h3D24
`define APC_ADDR_CONV_CTRL    14'h3D28
`define APC_ADDR_WIDTH        14

// Field layout
`define APC_LOW_CHANNELS      8
`define APC_HIGH_CHANNELS     5
`define APC_CHANNELS          13
`define APC_HIGH_PIN_DIGITAL_SELECT_MSB     4
`define APC_HIGH_UNIMPL_BIT   5
`define APC_HIGH_RSVD_BIT     6
`define APC_HIGH_BGREQ_BIT    7
`define APC_CHSEL_MSB         5
`define APC_CHSEL_LSB         2
`define APC_CHSEL_BANDGAP     4'hF

// Reset values
`define APC_SEL_LOW_RESET     8'h00
`define APC_SEL_HIGH_RESET    8'h00
`define APC_CONV_CTRL_RESET   8'h00

// AXI responses
`define APC_RESP_OKAY         2'h0
`define APC_RESP_SLVERR       2'h2

`endif

// [test/apc_chk.sv]
`timescale 1ns/1ps
module apc_chk (
  input wire        clock,
  input wire        rst,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_awready,
  input wire        s_axi_rvalid,
  input wire [31:0] s_axi_rdata,
  input wire [12:0] periph_out,
  input wire [12:0] periph_oe,
  input wire        other_bandgap_request,
  input wire [12:0] pin_out,
  input wire [12:0] pin_oe,
  input wire [12:0] pin_digital_in,
  input wire [12:0] pin_analog_enable,
  input wire        bandgap_enable
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  a_reset_all_analog: assert property (disable iff (1'b0) rst |-> pin_analog_enable == 13'h1FFF && !bandgap_enable)
    else $error("reset state wrong");
  a_din_blocked: assert property ((pin_digital_in & pin_analog_enable) == 13'h0000)
    else $error("digital input live on analog pin");
  a_oe_gated: assert property (pin_oe == ($past(periph_oe) & ~pin_analog_enable))
    else $error("pin enable not gated by select");
  a_out_gated: assert property (pin_out == ($past(periph_out) & ~pin_analog_enable))
    else $error("pin data not gated by select");
  a_bg_follows_other: assert property (other_bandgap_request |-> ##[1:4] bandgap_enable)
    else $error("band-gap not powered on request");
  a_sel_after_write: assert property ($changed(pin_analog_enable) |-> $past(s_axi_bvalid))
    else $error("select changed outside a write");
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  a_aw_one_pulse: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("address ready longer than a cycle");
  a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");
endmodule // apc_chk
bind apc_pin_config apc_chk i_apc_chk (.*);

// [test/apc_pads.sv]
`timescale 1ns/1ps
module apc_pads (
  input  wire        clock,
  input  wire        level,
  input  wire        req,
  output wire [12:0] pin_in,
  output reg  [12:0] periph_out,
  output wire [12:0] periph_oe,
  output wire        other_bandgap_request
);
  // Toggling data exposes stale or ungated drive
  initial periph_out = 13'h0AAA;
  always @(posedge clock) periph_out <= ~periph_out;
  assign pin_in = {13{level}};
  assign periph_oe = {13{level}};
  assign other_bandgap_request = req;
endmodule // apc_pads

// [test/tb_top.sv]
`timescale 1ns/1ps
`include "apc_consts.vh"
module tb_top;
  reg         clock = 0, rst = 0, level = 0, req = 0;
  reg         awv = 0, wv = 0, br = 1, arv = 0, rr = 1;
  reg  [13:0] aw = 0, ar = 0;
  reg  [31:0] wd = 0, rd;
  reg  [1:0]  rs;
  wire        awr, wr, bv, arr, rv, bg, route, ob;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  wire [12:0] pin_in, pout, poe, pdin, pan, po, pe;
  integer     err_count = 0, tests_run = 0, n;
  always #12.5 clock = ~clock;
  apc_pads i_apc_pads (.clock(clock), .level(level), .req(req), .pin_in(pin_in), .periph_out(po),
    .periph_oe(pe), .other_bandgap_request(ob));
  apc_pin_config i_apc_pin_config (.clock(clock), .rst(rst), .s_axi_awaddr(aw), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ar), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
    .pin_in(pin_in), .periph_out(po), .periph_oe(pe), .other_bandgap_request(ob), .pin_out(pout),
    .pin_oe(poe), .pin_digital_in(pdin), .pin_analog_enable(pan), .bandgap_enable(bg),
    .converter_bandgap_route(route));
  task close_out;
    begin
      $display("checks %0d errors %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task chk(input string w, input [31:0] e, input [31:0] g);
    begin
      tests_run = tests_run + 1;
      if (e !== g)
      begin
        err_count = err_count + 1;
        $display("ERROR %0s expected %h seen %h", w, e, g);
      end
    end
  endtask
  // Sampling at the edge sees pre-update values, which is the handshake
  task axw(input [13:0] a, input [7:0] d, input [1:0] er);
    begin
      aw <= a; wd <= {24'h000000, d}; awv <= 1; wv <= 1; rs = 2'h3;
      for (n = 0; n < 60 && rs === 2'h3; n = n + 1)
      begin
        @(posedge clock);
        if (awr) awv <= 0;
        if (wr) wv <= 0;
        if (bv) rs = bresp;
      end
      if (rs === 2'h3) begin err_count = err_count + 1; close_out; end
      chk("bresp", er, rs);
    end
  endtask
  task axr(input [13:0] a, input [31:0] ed, input [1:0] er);
    begin
      ar <= a; arv <= 1; rs = 2'h3;
      for (n = 0; n < 60 && rs === 2'h3; n = n + 1)
      begin
        @(posedge clock);
        if (arr) arv <= 0;
        if (rv) begin rs = rresp; rd = rdata; end
      end
      // Let an edge pass so a following request is not assigned in the same step
      @(posedge clock);
      if (rs === 2'h3) begin err_count = err_count + 1; close_out; end
      chk("rresp", er, rs);
      chk("rdata", ed, rd);
    end
  endtask
  initial
  begin
    rst <= 1;
    repeat (20) @(posedge clock);
    rst <= 0;
    @(posedge clock);
    axr(`APC_ADDR_SEL_LOW, 0, 0);
    axr(`APC_ADDR_SEL_HIGH, 0, 0);
    level <= 1;
    axw(`APC_ADDR_SEL_LOW, 8'hA5, 0);
    axw(`APC_ADDR_SEL_HIGH, 8'h3F, 0);
    @(posedge clock);
    chk("analog", 13'h005A, pan);
    axr(`APC_ADDR_SEL_HIGH, 32'h1F, 0);
    repeat (4) @(posedge clock);
    chk("din", 13'h1FA5, pdin);
    chk("oe", 13'h1FA5, poe);
    axw(`APC_ADDR_SEL_HIGH, 8'h9F, 0);
    @(posedge clock);
    chk("bg on", 1, bg);
    axw(`APC_ADDR_CONV_CTRL, 8'h3C, 0);
    @(posedge clock);
    chk("route", 1, route);
    axw(`APC_ADDR_CONV_CTRL, 8'h38, 0);
    @(posedge clock);
    chk("no route", 0, route);
    axw(`APC_ADDR_SEL_HIGH, 8'h1F, 0);
    @(posedge clock);
    chk("bg off", 0, bg);
    req <= 1;
    repeat (5) @(posedge clock);
    chk("bg other", 1, bg);
    req <= 0;
    axw(14'h0100, 8'hFF, `APC_RESP_SLVERR);
    axr(14'h0100, 0, `APC_RESP_SLVERR);
    rst <= 1;
    repeat (2) @(posedge clock);
    rst <= 0;
    @(posedge clock);
    chk("analog rst", 13'h1FFF, pan);
    axr(`APC_ADDR_SEL_LOW, 0, 0);
    close_out;
  end
endmodule // tb_top
